// *** logic/fesc_regs.svh ***
// Purpose: constants for the host-side erase/status controller of a parallel nor flash
// Assumes: clk at 20 MHz (50 ns period)
// Notes: command codes, unlock addresses, boot block ranges and timing counts
// Notes on behaviour
// R1: sector erase covers 4 KByte, block erase covers 64 KByte.
// R2: sector erase needs six writes, last is 50h to the sector address.
// R3: block erase needs six writes, last is 30h to the block address.
// R4: sixth write address latched at falling strobe, data at rising; erase follows.
// R5: during sector or block erase only the suspend command is honoured.
// R6: boot-protect low makes sector or block erase of the boot block ignored.
// R7: host holds boot-protect steady through every command sequence.
// R8: single b0h write suspends erase; read mode within about 20 us.
// R9: suspended region reads show erase toggle alternating, other two bits high.
// R10: outside suspended region reads give array data; programming allowed there.
// R11: single 30h write at any address resumes a suspended erase.
// R12: chip erase sets all ones; sixth write is 10h at aaah.
// R13: chip erase starts at first rising edge of sixth strobe; only polling reads.
// R14: chip erase ignored with boot-protect low; all commands ignored during it.
// R15: programming shows complemented bit 7, true value at end; rest 1 us later.
// R16: during erase bit 7 reads zero, after completion it reads one.
// R17: bit 7 polling valid after fourth program strobe or sixth erase strobe.
// R18: bit 6 inverts per read while busy, stops when done.
// R19: program in erase suspend toggles bit 6 and inverts bit 7.
// R20: bit 2 toggles during erase, steady during program.
// R21: no write accepted while output gate low, select high or strobe high.
// R22: boot block protected when boot-protect low; floating input reads high.
// R23: address latched on later falling edge, data on earlier rising edge.
// R24: erase sequences open with five fixed unlock writes.
// R25: a write breaking the sequence returns the device to read mode.
// R26: reset pin held low ends any operation and returns read mode.
// R27: erase completion returns to read mode and clears suspend record.
`ifndef FESC_REGS_SVH
`define FESC_REGS_SVH
`define FESC_ADDR_W 21
`define FESC_UNLOCK_A1 21'h000aaa
`define FESC_UNLOCK_A2 21'h000555
`define FESC_UNLOCK_D1 8'haa
`define FESC_UNLOCK_D2 8'h55
`define FESC_CMD_SETUP 8'h80
`define FESC_CMD_SECTOR 8'h50
`define FESC_CMD_BLOCK 8'h30
`define FESC_CMD_CHIP 8'h10
`define FESC_CMD_SUSPEND 8'hb0
`define FESC_CMD_RESUME 8'h30
`define FESC_SECTOR_MASK 21'h1ff000
`define FESC_BLOCK_MASK 21'h1f0000
`define FESC_BOOT_BOTTOM 21'h000000
`define FESC_BOOT_TOP 21'h1f0000
`define FESC_BIT_POLARITY 7
`define FESC_BIT_ACTIVITY 6
`define FESC_BIT_ERASE 2
`define FESC_CLK_HZ 20000000
`define FESC_SUSPEND_US 20
`define FESC_SUSPEND_CYC ((`FESC_SUSPEND_US * (`FESC_CLK_HZ / 1000000)))
`define FESC_SETTLE_US 1
`define FESC_SETTLE_CYC ((`FESC_SETTLE_US * (`FESC_CLK_HZ / 1000000)))
`define FESC_PHASE_CYC 2
`endif

// *** logic/fesc_pkg.sv ***
// Purpose: types for the host-side erase/status controller
// Assumes: fesc_regs.svh holds the numbers
// Notes: none
package fesc_pkg;
  typedef enum logic [2:0] {
    FESC_OP_SECTOR,
    FESC_OP_BLOCK,
    FESC_OP_CHIP,
    FESC_OP_SUSPEND,
    FESC_OP_RESUME,
    FESC_OP_READ
  } fesc_op_t;

  typedef struct packed {
    fesc_op_t op;
    logic [20:0] addr;
  } fesc_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic busy;
    logic toggling;
    logic erase_toggling;
  } fesc_rsp_t;

  typedef enum logic [1:0] {
    FESC_PH_SETUP,
    FESC_PH_STROBE,
    FESC_PH_HOLD
  } fesc_phase_t;
endpackage : fesc_pkg

// *** logic/fesc_host.sv ***
// Purpose: drives erase, suspend, resume and status polling on a parallel nor flash
// Assumes: pins sampled synchronously to clk; flash outputs settle within a phase
// Notes: each bus cycle is three phases of FESC_PHASE_CYC clocks
`timescale 1ns/1ps
`include "fesc_regs.svh"
module fesc_host
  import fesc_pkg::*;
#(
  parameter int PHASE_CYC = `FESC_PHASE_CYC,
  parameter logic BOOT_TOP = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // user request and response
  input wire logic req_valid,
  input fesc_req_t req,
  input wire logic boot_protect_req,
  output logic req_ready,
  output logic rsp_valid,
  output fesc_rsp_t rsp,
  output logic refused,
  // flash pins
  output logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_select_n,
  output logic flash_gate_n,
  output logic flash_strobe_n,
  output logic flash_reset_n,
  output logic flash_boot_protect_n
);
  typedef enum logic [2:0] {IDLE, WRITE, READ, SETTLE, DONE} fesc_st_t;
  localparam int SUSP_CYC = `FESC_SUSPEND_CYC;
  // sixth write of a sequence carries the command
  localparam logic [2:0] LAST_IDX = 3'h5;

  fesc_st_t st;
  fesc_phase_t ph;
  logic [15:0] cnt;
  logic [2:0] widx;
  fesc_op_t op;
  logic [20:0] tgt;
  logic [7:0] prev;
  logic have_prev;
  logic erasing;
  logic suspended;
  logic chip_busy;
  logic [20:0] susp_base;
  logic [20:0] susp_mask;

  wire is_erase = (req.op == FESC_OP_SECTOR) || (req.op == FESC_OP_BLOCK)
    || (req.op == FESC_OP_CHIP);
  wire [20:0] boot_base = BOOT_TOP ? `FESC_BOOT_TOP : `FESC_BOOT_BOTTOM;
  wire in_boot = ((req.addr & `FESC_BLOCK_MASK) == boot_base); // [R22]
  wire prot_hit = !boot_protect_req && is_erase
    && (in_boot || req.op == FESC_OP_CHIP); // [R6] [R14]
  wire busy_block = (chip_busy && req.op != FESC_OP_READ) // [R14]
    || (erasing && req.op != FESC_OP_SUSPEND && req.op != FESC_OP_READ) // [R5]
    || (req.op == FESC_OP_SUSPEND && !erasing)
    || (req.op == FESC_OP_RESUME && !suspended);
  wire refuse_now = prot_hit || busy_block || (is_erase && suspended);
  wire take = req_valid && req_ready;
  wire phase_end = (cnt == 16'(PHASE_CYC - 1));

  // unlock writes then command: index 0..5 for erase, 5 only for single writes
  logic [20:0] seq_addr;
  logic [7:0] seq_data;
  always_comb begin
    seq_addr = `FESC_UNLOCK_A1;
    seq_data = `FESC_UNLOCK_D1;
    case (widx)
      3'h0: begin seq_addr = `FESC_UNLOCK_A1; seq_data = `FESC_UNLOCK_D1; end // [R24]
      3'h1: begin seq_addr = `FESC_UNLOCK_A2; seq_data = `FESC_UNLOCK_D2; end
      3'h2: begin seq_addr = `FESC_UNLOCK_A1; seq_data = `FESC_CMD_SETUP; end
      3'h3: begin seq_addr = `FESC_UNLOCK_A1; seq_data = `FESC_UNLOCK_D1; end
      3'h4: begin seq_addr = `FESC_UNLOCK_A2; seq_data = `FESC_UNLOCK_D2; end
      default: begin
        case (op)
          FESC_OP_SECTOR: begin
            seq_addr = tgt & `FESC_SECTOR_MASK; // [R1] [R2]
            seq_data = `FESC_CMD_SECTOR;
          end
          FESC_OP_BLOCK: begin
            seq_addr = tgt & `FESC_BLOCK_MASK; // [R1] [R3]
            seq_data = `FESC_CMD_BLOCK;
          end
          FESC_OP_CHIP: begin
            seq_addr = `FESC_UNLOCK_A1; // [R12]
            seq_data = `FESC_CMD_CHIP;
          end
          FESC_OP_SUSPEND: begin
            seq_addr = tgt;
            seq_data = `FESC_CMD_SUSPEND; // [R8]
          end
          default: begin
            seq_addr = tgt;
            seq_data = `FESC_CMD_RESUME; // [R11]
          end
        endcase
      end
    endcase
  end

  assign req_ready = (st == IDLE);
  assign flash_reset_n = !sys_rst; // [R26]

  // read result decoding, polling bit evaluation
  wire [7:0] rd = flash_dq_in;
  wire act_flip = have_prev && (rd[`FESC_BIT_ACTIVITY] != prev[`FESC_BIT_ACTIVITY]); // [R18]
  wire era_flip = have_prev && (rd[`FESC_BIT_ERASE] != prev[`FESC_BIT_ERASE]); // [R20]
  wire in_susp = suspended && ((tgt & susp_mask) == susp_base); // [R9] [R10]
  // erase done when polarity bit reads one and activity stops toggling
  wire erase_done = (erasing || chip_busy) && rd[`FESC_BIT_POLARITY] && have_prev
    && !act_flip && !in_susp; // [R16] [R27]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= IDLE;
      ph <= FESC_PH_SETUP;
      cnt <= 16'h0000;
      widx <= 3'h0;
      op <= FESC_OP_READ;
      tgt <= 21'h000000;
      prev <= 8'h00;
      have_prev <= 1'b0;
      erasing <= 1'b0;
      suspended <= 1'b0;
      chip_busy <= 1'b0;
      susp_base <= 21'h000000;
      susp_mask <= 21'h000000;
      flash_addr <= 21'h000000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b1;
      flash_select_n <= 1'b1;
      flash_gate_n <= 1'b1;
      flash_strobe_n <= 1'b1;
      flash_boot_protect_n <= 1'b1;
      rsp_valid <= 1'b0;
      rsp <= '0;
      refused <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      refused <= 1'b0;
      case (st)
        IDLE: begin
          flash_boot_protect_n <= boot_protect_req; // [R7] only updated between sequences
          if (take) begin
            op <= req.op;
            tgt <= req.addr;
            cnt <= 16'h0000;
            ph <= FESC_PH_SETUP;
            if (req.op == FESC_OP_READ) begin
              st <= READ;
            end else if (refuse_now) begin
              refused <= 1'b1;
              rsp_valid <= 1'b1;
            end else begin
              widx <= is_erase ? 3'h0 : LAST_IDX;
              st <= WRITE;
            end
          end
        end
        WRITE: begin
          cnt <= phase_end ? 16'h0000 : cnt + 16'h0001;
          case (ph)
            FESC_PH_SETUP: begin
              // gate high before strobe so the write is accepted
              flash_gate_n <= 1'b1; // [R21]
              flash_addr <= seq_addr;
              flash_dq_out <= seq_data;
              flash_dq_oe <= 1'b0;
              flash_select_n <= 1'b0;
              if (phase_end) begin
                ph <= FESC_PH_STROBE;
              end
            end
            FESC_PH_STROBE: begin
              flash_strobe_n <= 1'b0; // [R4] [R23] address latched here
              if (phase_end) begin
                ph <= FESC_PH_HOLD;
              end
            end
            default: begin
              flash_strobe_n <= 1'b1; // [R4] [R13] data latched, operation starts
              if (phase_end) begin
                flash_select_n <= 1'b1;
                flash_dq_oe <= 1'b1;
                ph <= FESC_PH_SETUP;
                if (widx == LAST_IDX) begin
                  st <= (op == FESC_OP_SUSPEND) ? SETTLE : DONE;
                  have_prev <= 1'b0;
                  case (op)
                    FESC_OP_SECTOR, FESC_OP_BLOCK: erasing <= 1'b1;
                    FESC_OP_CHIP: chip_busy <= 1'b1;
                    FESC_OP_SUSPEND: begin
                      erasing <= 1'b0;
                      suspended <= 1'b1;
                      susp_base <= susp_base;
                    end
                    default: begin
                      erasing <= 1'b1; // [R11]
                      suspended <= 1'b0;
                    end
                  endcase
                  if (op == FESC_OP_SECTOR || op == FESC_OP_BLOCK) begin
                    susp_mask <= (op == FESC_OP_SECTOR) ? `FESC_SECTOR_MASK : `FESC_BLOCK_MASK;
                    susp_base <= tgt & ((op == FESC_OP_SECTOR) ? `FESC_SECTOR_MASK
                      : `FESC_BLOCK_MASK);
                  end
                end else begin
                  widx <= widx + 3'h1;
                end
              end
            end
          endcase
        end
        READ: begin
          cnt <= phase_end ? 16'h0000 : cnt + 16'h0001;
          flash_addr <= tgt;
          flash_dq_oe <= 1'b1;
          flash_select_n <= 1'b0;
          flash_gate_n <= 1'b0;
          if (phase_end) begin
            case (ph)
              FESC_PH_SETUP: ph <= FESC_PH_STROBE;
              FESC_PH_STROBE: ph <= FESC_PH_HOLD;
              default: begin
                // sample at end of third phase, then release the bus
                ph <= FESC_PH_SETUP;
                flash_select_n <= 1'b1;
                flash_gate_n <= 1'b1;
                prev <= rd;
                have_prev <= 1'b1;
                rsp.data <= rd; // [R10] [R15] [R17]
                rsp.toggling <= act_flip; // [R18] [R19]
                rsp.erase_toggling <= era_flip; // [R9] [R20]
                rsp.busy <= (erasing || chip_busy) && !erase_done;
                if (erase_done) begin
                  erasing <= 1'b0; // [R27]
                  chip_busy <= 1'b0;
                  suspended <= 1'b0;
                end
                rsp_valid <= 1'b1;
                st <= IDLE;
              end
            endcase
          end
        end
        SETTLE: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(SUSP_CYC - 1)) begin // [R8] wait for read mode
            cnt <= 16'h0000;
            st <= DONE;
          end
        end
        default: begin
          rsp_valid <= 1'b1;
          rsp.busy <= erasing || chip_busy;
          st <= IDLE;
        end
      endcase
    end
  end
endmodule : fesc_host

// *** dv/fesc_host_checker.sv ***
// Purpose: pin-level checks of the erase/status host
// Assumes: one clock, sys_rst async active high
// Notes: bound to fesc_host from the bench top file
`timescale 1ns/1ps
module fesc_host_checker
  import fesc_pkg::*;
#(
  parameter int PHASE_CYC = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // user side
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic refused,
  // flash pins
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_select_n,
  input wire logic flash_gate_n,
  input wire logic flash_strobe_n,
  input wire logic flash_reset_n,
  input wire logic flash_boot_protect_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  int low_cnt;
  // strobe length counted so the phase parameter can be checked exactly
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) low_cnt <= 0;
    else low_cnt <= flash_strobe_n ? 0 : low_cnt + 1;
  end
  write_inhibit_a: assert property (!flash_strobe_n |-> !flash_select_n && flash_gate_n
    && !flash_dq_oe) else $error("write outside select");
  read_gate_a: assert property (!flash_gate_n |-> flash_strobe_n && flash_dq_oe)
    else $error("read with strobe or drive");
  latch_stable_a: assert property (!flash_strobe_n |-> $stable(flash_addr)
    && $stable(flash_dq_out)) else $error("address or data moved under strobe");
  strobe_width_a: assert property ($rose(flash_strobe_n) |-> low_cnt == PHASE_CYC)
    else $error("strobe width");
  protect_steady_a: assert property (!flash_select_n |-> $stable(flash_boot_protect_n))
    else $error("protect moved in a cycle");
  reset_pin_a: assert property (flash_reset_n) else $error("device held in reset");
  refuse_quiet_a: assert property (refused |-> rsp_valid && flash_select_n
    && $past(flash_select_n)) else $error("refused request touched bus");
  idle_bus_a: assert property (req_ready |-> flash_select_n && flash_strobe_n)
    else $error("bus active while idle");
endmodule : fesc_host_checker

// *** dv/fesc_flash_model.sv ***
// Purpose: behavioural nor flash for the erase/status host
// Assumes: bottom boot block; erase far shorter than real parts
// Notes: released bus shows the inverse of the last read value
`timescale 1ns/1ps
module fesc_flash_model #(
  parameter longint ERASE_NS = 40000
) (
  // host pins
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_select_n,
  input wire logic flash_gate_n,
  input wire logic flash_strobe_n,
  input wire logic flash_reset_n,
  input wire logic flash_boot_protect_n,
  output logic [7:0] flash_dq_in
);
  longint t_end = 0;
  longint t_left = 0;
  int step = 0;
  logic chip = 0;
  logic susp = 0;
  logic tog6 = 0;
  logic tog2 = 0;
  logic [20:0] a_lat = 0;
  logic [20:0] base = 0;
  logic [20:0] mask = 0;
  logic [7:0] rd = 8'hff;
  task automatic take(input logic [7:0] d);
    logic odd;
    odd = step == 1 || step == 4;
    if ($time < t_end) begin
      if (!chip && d == 8'hb0) begin
        t_left = t_end - $time;
        t_end = 0;
        susp = 1;
      end
    end else if (susp && d == 8'h30) begin
      t_end = $time + t_left;
      susp = 0;
    end else if (step < 5) begin
      if (a_lat == (odd ? 21'h555 : 21'haaa) && d == (step == 2 ? 8'h80 : odd ? 8'h55 : 8'haa))
        step++;
      else step = 0;
    end else begin
      step = 0;
      chip = d == 8'h10;
      mask = d == 8'h50 ? 21'h1ff000 : d == 8'h30 ? 21'h1f0000 : 21'h0;
      base = a_lat & mask;
      if ((chip ? a_lat == 21'haaa : mask != 0) && (flash_boot_protect_n
          || !chip && (base & 21'h1f0000) != 0)) t_end = $time + ERASE_NS;
    end
  endtask : take
  always @(negedge flash_strobe_n)
    if (!flash_select_n && flash_gate_n) a_lat = flash_addr;
  always @(posedge flash_strobe_n or negedge flash_reset_n) begin
    if (!flash_reset_n) begin
      t_end = 0;
      susp = 0;
      step = 0;
    end else if (!flash_select_n && flash_gate_n) take(flash_dq_out);
  end
  always @(negedge flash_gate_n) begin
    #1;
    if ($time < t_end) begin
      tog6 = !tog6;
      tog2 = !tog2;
      rd = {1'b0, tog6, 3'b0, tog2, 2'b0};
    end else if (susp && (flash_addr & mask) == base) begin
      tog2 = !tog2;
      rd = {2'b11, 3'b0, tog2, 2'b0};
    end else rd = 8'hff;
  end
  assign flash_dq_in = !flash_select_n && !flash_gate_n ? rd : ~rd;
endmodule : fesc_flash_model

// *** dv/fesc_host_bench.sv ***
// Purpose: self-checking bench for the erase/status host
// Assumes: PHASE_CYC of 2, model erase of 40 us
// Notes: bottom boot block variant
`timescale 1ns/1ps
module fesc_host_bench;
  import fesc_pkg::*;
  logic clk = 0;
  logic sys_rst = 1;
  logic req_valid = 0;
  logic boot_protect_req = 1;
  fesc_req_t req = '0;
  fesc_rsp_t rsp, r;
  logic req_ready, rsp_valid, refused, flash_dq_oe, rf;
  logic flash_select_n, flash_gate_n, flash_strobe_n, flash_reset_n, flash_boot_protect_n;
  logic [20:0] flash_addr;
  logic [7:0] flash_dq_in, flash_dq_out;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  fesc_host #(.PHASE_CYC(2)) u_dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .boot_protect_req(boot_protect_req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .refused(refused), .flash_addr(flash_addr),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_select_n(flash_select_n), .flash_gate_n(flash_gate_n),
    .flash_strobe_n(flash_strobe_n), .flash_reset_n(flash_reset_n),
    .flash_boot_protect_n(flash_boot_protect_n));
  fesc_flash_model u_model (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_select_n(flash_select_n), .flash_gate_n(flash_gate_n),
    .flash_strobe_n(flash_strobe_n), .flash_reset_n(flash_reset_n),
    .flash_boot_protect_n(flash_boot_protect_n), .flash_dq_in(flash_dq_in));
  always #25 clk = ~clk;
  // ceiling well above five erases of 800 cycles plus polling
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic op(input fesc_op_t o, input logic [20:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {o, a};
    @(posedge clk);
    req_valid <= 1'b0;
    // a refused answer pulses in the cycle right after the take edge
    #1;
    for (int i = 0; i < 1000 && rsp_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("answer", rsp_valid, 1);
    r = rsp;
    rf = refused;
  endtask : op
  task automatic wait_done(input logic [20:0] a);
    for (int i = 0; i < 300 && (i == 0 || r.busy); i++) op(FESC_OP_READ, a);
    check("done", {r.busy, r.data}, 9'h0ff);
  endtask : wait_done
  task automatic t_sector;
    op(FESC_OP_SECTOR, 21'h012345);
    check("sector go", rf, 0);
    check("sector base", u_model.base, 21'h012000);
    op(FESC_OP_READ, 21'h012345);
    check("poll", {r.busy, r.data[7]}, 2'b10);
    op(FESC_OP_READ, 21'h012345);
    check("toggles", {r.toggling, r.erase_toggling}, 2'b11);
    op(FESC_OP_BLOCK, 21'h050000);
    check("erase busy", rf, 1);
    wait_done(21'h012345);
  endtask : t_sector
  task automatic t_suspend;
    op(FESC_OP_BLOCK, 21'h034567);
    op(FESC_OP_RESUME, 21'h0);
    check("resume idle", rf, 1);
    t0 = cyc;
    op(FESC_OP_SUSPEND, 21'h034567);
    check("suspend", {rf, 1'(cyc - t0 > 400)}, 2'b01);
    op(FESC_OP_READ, 21'h03ffff);
    op(FESC_OP_READ, 21'h030000);
    check("suspended", {r.data[7:6], r.erase_toggling}, 3'b111);
    op(FESC_OP_READ, 21'h100000);
    check("outside", r.data, 8'hff);
    op(FESC_OP_SUSPEND, 21'h0);
    check("suspend idle", rf, 1);
    op(FESC_OP_RESUME, 21'h001234);
    check("resume", rf, 0);
    op(FESC_OP_READ, 21'h034567);
    check("resumed", r.data[7], 0);
    wait_done(21'h034567);
  endtask : t_suspend
  task automatic t_protect;
    @(posedge clk) boot_protect_req <= 1'b0;
    op(FESC_OP_SECTOR, 21'h00f000);
    check("boot sector", rf, 1);
    op(FESC_OP_CHIP, 21'h000aaa);
    check("chip locked", rf, 1);
    op(FESC_OP_SECTOR, 21'h010000);
    check("next sector", rf, 0);
    wait_done(21'h010000);
    @(posedge clk) boot_protect_req <= 1'b1;
  endtask : t_protect
  task automatic t_chip;
    op(FESC_OP_CHIP, 21'h000aaa);
    check("chip go", rf, 0);
    op(FESC_OP_SUSPEND, 21'h0);
    check("chip quiet", rf, 1);
    wait_done(21'h0);
  endtask : t_chip
  task automatic t_reset;
    op(FESC_OP_SECTOR, 21'h020000);
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    op(FESC_OP_READ, 21'h020000);
    check("reset ends", {r.busy, r.data}, 9'h0ff);
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_sector();
    t_suspend();
    t_protect();
    t_chip();
    t_reset();
    stop_test();
  end
endmodule : fesc_host_bench
bind fesc_host fesc_host_checker #(.PHASE_CYC(PHASE_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .refused(refused), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_select_n(flash_select_n),
  .flash_gate_n(flash_gate_n), .flash_strobe_n(flash_strobe_n),
  .flash_reset_n(flash_reset_n), .flash_boot_protect_n(flash_boot_protect_n));
